// ---- pkg/cpm_pkg.sv ----
// Constants and types for the core power mode controller
//
// Overview of operation
// - Idle functional units drop to low power automatically.
// - Execution units powered per instructions in flight.
// - Nap stops fetch; only timer and test clocks run.
// - Nap dozes to snoop via quiesce request/acknowledge.
// - Sleep stops snooping and units; PLL stays locked.
// - Core frequency divisible by two or four.
// - Supervisor-only fetch throttle control slows execution.
// - Core clock ratio chosen by six configuration inputs.
// - Status and power indications exposed to system.
package cpm_pkg;

  // Requested power mode codes
  localparam logic [1:0] CPM_MODE_RUN   = 2'h0;
  localparam logic [1:0] CPM_MODE_NAP   = 2'h1;
  localparam logic [1:0] CPM_MODE_SLEEP = 2'h2;
  localparam logic [1:0] CPM_MODE_DEEP  = 2'h3;

  // Core frequency divide codes
  localparam logic [1:0] CPM_DIV_1 = 2'h0;
  localparam logic [1:0] CPM_DIV_2 = 2'h1;
  localparam logic [1:0] CPM_DIV_4 = 2'h2;

  // Widths and reset values
  localparam int          CPM_PLL_CFG_W   = 6;
  localparam int          CPM_THR_IVL_W   = 8;
  localparam logic [5:0]  CPM_PLL_RST     = 6'h00;
  localparam logic [8:0]  CPM_THR_RST     = 9'h000;
  localparam logic [7:0]  CPM_THR_CNT_RST = 8'h00;
  localparam logic [1:0]  CPM_DIV_CNT_RST = 2'h0;

  // Field positions of the fetch throttle control word
  localparam int CPM_THR_EN_BIT = 0;
  localparam int CPM_THR_IVL_LO = 1;

  typedef enum logic [5:0] {
    CPM_ST_RUN   = 6'h01,
    CPM_ST_QREQ  = 6'h02,
    CPM_ST_NAP   = 6'h04,
    CPM_ST_DOZE  = 6'h08,
    CPM_ST_SLEEP = 6'h10,
    CPM_ST_DEEP  = 6'h20
  } cpm_state_t;

endpackage : cpm_pkg

// ---- hdl/cpm_core_power.sv ----
// Core power mode controller: idle gating, modes, divide, fetch throttle
`timescale 1ns/100ps
`default_nettype none
module cpm_core_power
  import cpm_pkg::*;
#(
  parameter int UNITS = 4
) (
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  input  wire logic [UNITS-1:0]         unit_busy,
  input  wire logic [UNITS-1:0]         unit_req,
  input  wire logic                     pm_enter,
  input  wire logic [1:0]               pm_mode,
  input  wire logic                     wake_evt,
  input  wire logic                     qack,
  input  wire logic                     tb_enable,
  input  wire logic [1:0]               core_frequency_divide,
  input  wire logic                     thr_wr,
  input  wire logic                     thr_supervisor,
  input  wire logic [8:0]               thr_wdata,
  input  wire logic [CPM_PLL_CFG_W-1:0] pll_cfg,
  output logic [UNITS-1:0]              unit_pwr_en,
  output logic                          qreq,
  output logic                          fetch_en,
  output logic                          core_clk_en,
  output logic                          snoop_en,
  output logic                          tb_clk_en,
  output logic                          test_clk_en,
  output logic                          pll_run,
  output logic                          pm_nap,
  output logic                          pm_sleep,
  output logic                          pm_deep,
  output logic [8:0]                    fetch_throttle_control,
  output logic [CPM_PLL_CFG_W-1:0]      pll_ratio
);

  cpm_state_t                state;
  cpm_state_t                next_state;
  logic [1:0]                div_cnt;
  logic                      next_tick;
  logic [CPM_THR_IVL_W-1:0]  thr_cnt;
  logic                      thr_ok;
  logic                      pll_cap_done;
  logic                      run_next;

  // Mode sequencing with quiesce handshake
  always_comb begin
    next_state = state;
    unique case (state)
      CPM_ST_RUN: begin
        if (pm_enter && pm_mode != CPM_MODE_RUN) begin
          next_state = CPM_ST_QREQ;
        end
      end
      CPM_ST_QREQ: begin
        if (wake_evt) begin
          next_state = CPM_ST_RUN;
        end else if (qack) begin
          unique case (pm_mode)
            CPM_MODE_SLEEP: next_state = CPM_ST_SLEEP;
            CPM_MODE_DEEP:  next_state = CPM_ST_DEEP;
            default:        next_state = CPM_ST_NAP;
          endcase
        end
      end
      CPM_ST_NAP: begin
        if (wake_evt) begin
          next_state = CPM_ST_RUN;
        end else if (!qack) begin
          next_state = CPM_ST_DOZE;
        end
      end
      CPM_ST_DOZE: begin
        if (wake_evt) begin
          next_state = CPM_ST_RUN;
        end else if (qack) begin
          next_state = CPM_ST_NAP;
        end
      end
      CPM_ST_SLEEP: begin
        if (wake_evt) begin
          next_state = CPM_ST_RUN;
        end
      end
      CPM_ST_DEEP: begin
        // Clean exit relies on the system resetting the core
        if (wake_evt) begin
          next_state = CPM_ST_RUN;
        end
      end
      default: next_state = CPM_ST_RUN;
    endcase
  end

  assign run_next = (next_state == CPM_ST_RUN);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= CPM_ST_RUN;
    end else begin
      state <= next_state;
    end
  end

  // Status and handshake outputs follow the next state
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      qreq        <= 1'b0;
      snoop_en    <= 1'b1;
      tb_clk_en   <= 1'b0;
      test_clk_en <= 1'b1;
      pll_run     <= 1'b1;
      pm_nap      <= 1'b0;
      pm_sleep    <= 1'b0;
      pm_deep     <= 1'b0;
    end else begin
      qreq        <= !run_next;
      snoop_en    <= run_next || next_state == CPM_ST_DOZE;
      tb_clk_en   <= tb_enable && next_state != CPM_ST_SLEEP
                     && next_state != CPM_ST_DEEP;
      test_clk_en <= next_state != CPM_ST_SLEEP
                     && next_state != CPM_ST_DEEP;
      pll_run     <= next_state != CPM_ST_DEEP;
      pm_nap      <= next_state == CPM_ST_NAP
                     || next_state == CPM_ST_DOZE;
      pm_sleep    <= next_state == CPM_ST_SLEEP;
      pm_deep     <= next_state == CPM_ST_DEEP;
    end
  end

  // Per-unit power: on only while busy or targeted
  genvar gi;
  generate
    for (gi = 0; gi < UNITS; gi++) begin : g_unit
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          unit_pwr_en[gi] <= 1'b0;
        end else begin
          unit_pwr_en[gi] <= run_next
                             && (unit_busy[gi] || unit_req[gi]);
        end
      end
    end
  endgenerate

  // Core clock enable divider
  always_comb begin
    unique case (core_frequency_divide)
      CPM_DIV_2: next_tick = (div_cnt[0] == 1'b0);
      CPM_DIV_4: next_tick = (div_cnt == 2'h0);
      default:   next_tick = 1'b1;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      div_cnt     <= CPM_DIV_CNT_RST;
      core_clk_en <= 1'b0;
    end else begin
      div_cnt     <= run_next ? div_cnt + 2'h1 : CPM_DIV_CNT_RST;
      core_clk_en <= run_next && next_tick;
    end
  end

  // Fetch throttle control, supervisor writes only
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fetch_throttle_control <= CPM_THR_RST;
    end else if (thr_wr && thr_supervisor) begin
      fetch_throttle_control <= thr_wdata;
    end
  end

  assign thr_ok = !fetch_throttle_control[CPM_THR_EN_BIT]
                  || thr_cnt == CPM_THR_CNT_RST;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      thr_cnt  <= CPM_THR_CNT_RST;
      fetch_en <= 1'b0;
    end else begin
      if (!run_next || thr_ok) begin
        thr_cnt <= fetch_throttle_control[8:CPM_THR_IVL_LO];
      end else begin
        thr_cnt <= thr_cnt - 8'h01;
      end
      fetch_en <= run_next && next_tick && thr_ok;
    end
  end

  // Ratio straps caught once after reset release
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pll_ratio    <= CPM_PLL_RST;
      pll_cap_done <= 1'b0;
    end else if (!pll_cap_done) begin
      pll_ratio    <= pll_cfg;
      pll_cap_done <= 1'b1;
    end
  end

  // Checks
  sequence s_nap_to_doze;
    state == CPM_ST_NAP ##1 state == CPM_ST_DOZE;
  endsequence

  a_nap_no_fetch: assert property (@(posedge clk) disable iff (!rst_n)
    pm_nap |-> !fetch_en && !core_clk_en && test_clk_en)
    else $error("Fetch or core clock running in nap");

  a_doze_snoop_q: assert property (@(posedge clk) disable iff (!rst_n)
    s_nap_to_doze |-> snoop_en && qreq && pm_nap)
    else $error("Doze without snoop or quiesce request");

  a_doze_return: assert property (@(posedge clk) disable iff (!rst_n)
    state == CPM_ST_DOZE && qack && !wake_evt |=> state == CPM_ST_NAP
    && !snoop_en)
    else $error("Doze did not return to nap");

  a_sleep_quiet: assert property (@(posedge clk) disable iff (!rst_n)
    pm_sleep |-> !snoop_en && unit_pwr_en == '0 && !tb_clk_en
    && pll_run)
    else $error("Sleep left logic running or PLL stopped");

  a_deep_pll: assert property (@(posedge clk) disable iff (!rst_n)
    pm_deep |-> !pll_run && qreq)
    else $error("Deep sleep kept PLL run request");

  a_div_two: assert property (@(posedge clk) disable iff (!rst_n)
    core_clk_en && core_frequency_divide == CPM_DIV_2
    && $past(core_frequency_divide) == CPM_DIV_2
    && state == CPM_ST_RUN && !pm_enter
    |=> !core_clk_en ##1 (core_clk_en
    || $past(core_frequency_divide) != CPM_DIV_2 || !$past(run_next)))
    else $error("Divide by two cadence wrong");

  a_unit_idle: assert property (@(posedge clk) disable iff (!rst_n)
    ##1 $past(state == CPM_ST_RUN) && $past(run_next)
    && $past(!unit_busy[0] && !unit_req[0]) |-> !unit_pwr_en[0])
    else $error("Idle unit left powered");

  a_throttle_user: assert property (@(posedge clk) disable iff (!rst_n)
    thr_wr && !thr_supervisor |=> $stable(fetch_throttle_control))
    else $error("User write changed fetch throttle");

  a_pll_capture: assert property (@(posedge clk) disable iff (!rst_n)
    pll_cap_done |=> $stable(pll_ratio))
    else $error("PLL ratio changed after capture");

endmodule : cpm_core_power
`default_nettype wire

// ---- tb/cpm_sys_model.sv ----
// System controller model answering the quiesce handshake
`timescale 1ns/100ps
`default_nettype none
module cpm_sys_model (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic qreq,
  input  wire logic snoop,
  output logic      qack
);
  logic [1:0] dly;

  // Slow grant: acknowledge four cycles after the request
  always_ff @(posedge clk) begin
    if (!rst_n || !qreq) begin
      dly  <= 2'h0;
      qack <= 1'b0;
    end else if (snoop) begin
      qack <= 1'b0;
    end else if (dly != 2'h3) begin
      dly <= dly + 2'h1;
    end else begin
      qack <= 1'b1;
    end
  end
endmodule : cpm_sys_model
`default_nettype wire

// ---- tb/tb_top.sv ----
// Testbench for the core power mode controller
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import cpm_pkg::*;
  logic       clk, rst_n, pm_enter, wake_evt, qack, tb_enable, snoop;
  logic       thr_wr, thr_supervisor, qreq, fetch_en, core_clk_en;
  logic       snoop_en, tb_clk_en, test_clk_en, pll_run;
  logic       pm_nap, pm_sleep, pm_deep;
  logic [3:0] unit_busy, unit_req, unit_pwr_en;
  logic [1:0] pm_mode, core_frequency_divide;
  logic [8:0] thr_wdata, fetch_throttle_control;
  logic [5:0] pll_cfg, pll_ratio;
  wire  [8:0] outs;
  int         bad_count, samples_checked;

  assign outs = {fetch_en, core_clk_en, snoop_en, tb_clk_en, test_clk_en,
                 pll_run, pm_nap, pm_sleep, pm_deep};

  cpm_core_power #(.UNITS(4)) u_dut (
    .clk, .rst_n, .unit_busy, .unit_req, .pm_enter, .pm_mode, .wake_evt,
    .qack, .tb_enable, .core_frequency_divide, .thr_wr, .thr_supervisor,
    .thr_wdata, .pll_cfg, .unit_pwr_en, .qreq, .fetch_en, .core_clk_en,
    .snoop_en, .tb_clk_en, .test_clk_en, .pll_run, .pm_nap, .pm_sleep,
    .pm_deep, .fetch_throttle_control, .pll_ratio);

  cpm_sys_model u_sys (.clk, .rst_n, .qreq, .snoop, .qack);

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc

  task automatic chk(input string what, input logic [8:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic count(output logic [8:0] c, f);
    c = 9'h000;
    f = 9'h000;
    repeat (16) begin
      cyc(1);
      c += 9'(core_clk_en === 1'b1);
      f += 9'(fetch_en === 1'b1);
    end
  endtask : count

  task automatic thr_write(input logic sup, input logic [8:0] w);
    thr_supervisor = sup;
    thr_wdata = w;
    thr_wr = 1'b1;
    cyc(1);
    thr_wr = 1'b0;
    cyc(1);
  endtask : thr_write

  task automatic t_run;
    logic [8:0] c, f;
    unit_busy = 4'h5;
    unit_req = 4'h2;
    cyc(2);
    chk("unit power", 9'(unit_pwr_en), 9'h007);
    unit_busy = 4'h0;
    unit_req = 4'h0;
    cyc(2);
    chk("unit idle", 9'(unit_pwr_en), 9'h000);
    for (int i = 0; i < 3; i++) begin
      core_frequency_divide = 2'(i);
      cyc(4);
      count(c, f);
      chk("core ticks", c, 9'(16 >> i));
      chk("fetch ticks", f, 9'(16 >> i));
    end
    core_frequency_divide = CPM_DIV_1;
    thr_write(1'b0, 9'h007);
    chk("user write", fetch_throttle_control, 9'h000);
    thr_write(1'b1, 9'h007);
    chk("sup write", fetch_throttle_control, 9'h007);
    count(c, f);
    chk("throttled fetch", f, 9'h004);
    thr_write(1'b1, 9'h000);
    pm_enter = 1'b1;
    cyc(1);
    pm_enter = 1'b0;
    cyc(2);
    chk("run request", 9'(qreq), 9'h000);
    tb_enable = 1'b0;
    cyc(2);
    chk("time base off", 9'(tb_clk_en), 9'h000);
    tb_enable = 1'b1;
    cyc(2);
    chk("time base on", 9'(tb_clk_en), 9'h001);
    $display("run test done");
  endtask : t_run

  task automatic t_mode(input logic [1:0] m, input logic [8:0] exp);
    int n;
    n = 0;
    unit_busy = 4'hf;
    pm_mode = m;
    pm_enter = 1'b1;
    cyc(1);
    pm_enter = 1'b0;
    cyc(1);
    chk("qreq", 9'(qreq), 9'h001);
    while ({pm_nap, pm_sleep, pm_deep} === 3'h0 && n < 20) begin
      cyc(1);
      n++;
    end
    chk("mode outputs", outs, exp);
    chk("units off", 9'(unit_pwr_en), 9'h000);
    if (m == CPM_MODE_NAP) begin
      snoop = 1'b1;
      cyc(3);
      chk("doze snoop", 9'(snoop_en), 9'h001);
      snoop = 1'b0;
      cyc(3);
      chk("nap snoop", 9'(snoop_en), 9'h000);
    end
    wake_evt = 1'b1;
    cyc(1);
    wake_evt = 1'b0;
    unit_busy = 4'h0;
    cyc(1);
    chk("wake qreq", 9'(qreq), 9'h000);
    $display("mode %0d test done", m);
  endtask : t_mode

  task automatic t_abort;
    pm_mode = CPM_MODE_NAP;
    pm_enter = 1'b1;
    cyc(1);
    pm_enter = 1'b0;
    wake_evt = 1'b1;
    cyc(1);
    wake_evt = 1'b0;
    cyc(1);
    chk("abort qreq", 9'(qreq), 9'h000);
    chk("abort nap", 9'(pm_nap), 9'h000);
    $display("abort test done");
  endtask : t_abort

  task automatic conclude;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : conclude

  initial begin
    #20000;
    bad_count++;
    $display("watchdog expired");
    conclude();
  end

  initial begin
    {pm_enter, wake_evt, thr_wr, thr_supervisor, snoop} = 5'h00;
    {unit_busy, unit_req, pm_mode, core_frequency_divide} = 12'h000;
    thr_wdata = 9'h000;
    tb_enable = 1'b1;
    pll_cfg = 6'h2b;
    rst_n = 1'b0;
    cyc(10);
    chk("reset outputs", outs, 9'h058);
    chk("reset qreq", 9'(qreq), 9'h000);
    chk("reset units", 9'(unit_pwr_en), 9'h000);
    rst_n = 1'b1;
    cyc(2);
    chk("pll ratio", 9'(pll_ratio), 9'h02b);
    t_run();
    t_abort();
    t_mode(CPM_MODE_NAP, 9'h03c);
    t_mode(CPM_MODE_SLEEP, 9'h00a);
    t_mode(CPM_MODE_DEEP, 9'h001);
    pll_cfg = 6'h15;
    rst_n = 1'b0;
    cyc(2);
    rst_n = 1'b1;
    cyc(2);
    chk("relock ratio", 9'(pll_ratio), 9'h015);
    conclude();
  end
endmodule : tb_top
`default_nettype wire
